/* File: dcsc_exc_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module dcsc_exc_filter
  import dcsc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [2:0] code_in, // raw exception lines
  output logic [2:0] code_ok, // accepted code
  output logic code_rsv // reserved code accepted
);
  logic [2:0] smp_ff; // previous sample
  logic [2:0] nxt_smp;
  logic [2:0] acc_ff; // code stable two clocks
  logic [2:0] nxt_acc;

  // accept only when two samples in a row agree
  always_comb begin
    nxt_smp = code_in;
    nxt_acc = acc_ff;
    if (code_in == smp_ff) begin
      nxt_acc = code_in;
    end
  end

  // register samples
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      smp_ff <= EXC_NONE;
      acc_ff <= EXC_NONE;
    end else begin
      smp_ff <= nxt_smp;
      acc_ff <= nxt_acc;
    end
  end

  assign code_ok = acc_ff;
  assign code_rsv = (acc_ff == EXC_RSV1) || (acc_ff == EXC_RSV0);
endmodule
`default_nettype wire

/* File: dcsc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcsc_mem_model (
  input wire logic clk, // clock
  input wire logic fetch_req, // word wanted
  input wire logic [31:0] fetch_addr, // byte address
  output logic fetch_ack, // word ready
  output logic [15:0] fetch_data // word
);
  logic [15:0] mem [16]; // table words
  initial begin
    foreach (mem[i]) mem[i] = 16'h0;
  end
  // answer every other cycle, scramble data while idle
  always_ff @(posedge clk) begin
    fetch_ack <= fetch_req && !fetch_ack;
    fetch_data <= (fetch_req && !fetch_ack) ? mem[fetch_addr[4:1]] : ~fetch_data;
  end
endmodule
`default_nettype wire

/* File: dcsc_pcl_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module dcsc_pcl_edge
  import dcsc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic line_in, // peripheral control line
  output logic level, // registered line level
  output logic fall_p // qualified falling edge pulse
);
  logic lvl_ff; // line level
  logic arm_ff; // high seen since last edge
  logic [1:0] low_ff; // clocks spent low
  logic nxt_lvl;
  logic nxt_arm;
  logic [1:0] nxt_low;
  logic nxt_fall;
  logic fall_ff;

  // count low clocks after a high, fire once
  always_comb begin
    nxt_lvl = line_in;
    nxt_arm = arm_ff;
    nxt_low = low_ff;
    nxt_fall = 1'b0;
    if (line_in) begin
      nxt_arm = 1'b1;
      nxt_low = 2'h0;
    end else if (arm_ff) begin
      nxt_low = low_ff + 2'h1;
      if (nxt_low == PCL_LOW_CLKS) begin
        nxt_fall = 1'b1;
        nxt_arm = 1'b0;
      end
    end
  end

  // register detector state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvl_ff <= 1'b1;
      arm_ff <= 1'b0;
      low_ff <= 2'h0;
      fall_ff <= 1'b0;
    end else begin
      lvl_ff <= nxt_lvl;
      arm_ff <= nxt_arm;
      low_ff <= nxt_low;
      fall_ff <= nxt_fall;
    end
  end

  assign level = lvl_ff;
  assign fall_p = fall_ff;
endmodule
`default_nettype wire

/* File: dcsc_pkg.sv */
package dcsc_pkg;
  // channels and register offsets
  localparam int NCH = 4;
  localparam logic [5:0] OFF_STAT = 6'h00;
  localparam logic [5:0] OFF_ERR = 6'h01;
  localparam logic [5:0] OFF_MODE = 6'h05;
  localparam logic [5:0] OFF_CTRL = 6'h07;
  localparam logic [5:0] OFF_MTC = 6'h0a;
  localparam logic [5:0] OFF_MARH = 6'h0c;
  localparam logic [5:0] OFF_MARL = 6'h0e;
  localparam logic [5:0] OFF_BTC = 6'h1a;
  localparam logic [5:0] OFF_BARH = 6'h1c;
  localparam logic [5:0] OFF_BARL = 6'h1e;
  localparam logic [5:0] OFF_NVEC = 6'h25;
  localparam logic [5:0] OFF_EVEC = 6'h27;
  localparam logic [5:0] OFF_PRIO = 6'h2d;
  localparam logic [5:0] OFF_BFC = 6'h39;
  // status bits
  localparam int ST_COC = 7;
  localparam int ST_BLK = 6;
  localparam int ST_NDT = 5;
  localparam int ST_ERR = 4;
  localparam int ST_ACT = 3;
  localparam int ST_PCT = 1;
  localparam int ST_PCS = 0;
  // control bits
  localparam int CT_START = 7;
  localparam int CT_CONT = 6;
  localparam int CT_INTEN = 3;
  // mode register fields
  localparam int MD_CHAIN_LO = 2;
  localparam int MD_PCLINT = 0;
  localparam logic [1:0] CHN_NONE = 2'h0;
  localparam logic [1:0] CHN_ARRAY = 2'h2;
  localparam logic [1:0] CHN_LINK = 2'h3;
  // entry sizes in 16-bit words, array step in bytes
  localparam logic [2:0] ARR_WORDS = 3'h3;
  localparam logic [2:0] LNK_WORDS = 3'h5;
  localparam logic [31:0] ARR_STEP = 32'h0000_0006;
  // reset values
  localparam logic [7:0] VEC_RST = 8'h0f;
  // error kind codes
  localparam logic [7:0] ERC_CONFIG = 8'h01;
  localparam logic [7:0] ERC_TIMING = 8'h02;
  localparam logic [7:0] ERC_ADDR = 8'h05;
  localparam logic [7:0] ERC_BUS = 8'h09;
  localparam logic [7:0] ERC_COUNT = 8'h0d;
  // exception line codes
  localparam logic [2:0] EXC_NONE = 3'h7;
  localparam logic [2:0] EXC_HALT = 3'h6;
  localparam logic [2:0] EXC_BERR = 3'h5;
  localparam logic [2:0] EXC_RETRY = 3'h4;
  localparam logic [2:0] EXC_RR = 3'h3;
  localparam logic [2:0] EXC_RSV1 = 3'h2;
  localparam logic [2:0] EXC_RSV0 = 3'h1;
  localparam logic [2:0] EXC_RESET = 3'h0;
  // least low time of the line
  localparam logic [1:0] PCL_LOW_CLKS = 2'h2;
  // sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_FETCH, SQ_APPLY} dcsc_sq_t;
endpackage

/* File: dcsc_top.sv */
// What this block does
// - done during acknowledge sets normal termination flag
// - any error sets flag and loads code
// - error flag clears by write one only
// - active set by start, cleared by termination
// - request is enable AND flag OR
// - request follows enable, no latching
// - acknowledge picks channel by transfer priority
// - vector is error or normal, with acknowledge
// - reset loads vectors with uninitialized value
// - counter zero continues on chain or continue
// - array entry is address then count
// - fetch entry, decrement count, advance base
// - base count zero means last block
// - odd table address or zero count errors
// - base function code drives entry fetches
// - linked entry: address, count, link
// - zero link means chain exhausted
// - linked odd address or zero count errors
// - exception lines decoded per fixed table
// - exception code acts after two stable clocks
// - reserved code stalls cycle termination
// - bus request only with no exception
// - status flags write-one-clear, two ignore writes
// - line fall held two clocks sets transition
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dcsc_top
  import dcsc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [7:0] reg_addr, // channel in [7:6], offset below
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  output logic int_req, // interrupt request
  input wire logic interrupt_acknowledge_in, // acknowledge pulse
  output logic [7:0] vec_data, // vector on low data lines
  output logic vec_data_transfer_acknowledge, // vector valid pulse
  input wire logic [3:0] periph_ack, // channel acknowledging peripheral
  input wire logic [3:0] done_in, // completion line
  input wire logic [3:0] peripheral_control_line, // per channel
  input wire logic [3:0] xfer_req, // pending transfer requests
  output logic bus_request_out, // bus request, active high
  input wire logic [3:0] blk_end, // memory counter reached zero
  input wire logic [3:0] ext_err, // transfer logic error
  input wire logic [7:0] ext_err_code, // code of that error
  input wire logic cyc_busy, // a channel bus cycle is running
  input wire logic [1:0] cyc_ch, // channel of that cycle
  input wire logic data_transfer_acknowledge, // cycle acknowledge
  output logic cyc_end, // cycle may terminate
  output logic exc_hold, // halt, retry, relinquish
  output logic [3:0] chan_active, // active flags
  output logic fetch_req, // descriptor word read request
  output logic [31:0] fetch_addr, // byte address of the word
  output logic [2:0] fetch_fc, // function code for fetch
  input wire logic fetch_ack, // word returned
  input wire logic [15:0] fetch_data, // returned word
  input wire logic exception_code_line0, // exception code bit 0
  input wire logic exception_code_line1, // exception code bit 1
  input wire logic exception_code_line2 // exception code bit 2
);
  // exception decode
  logic [2:0] exc_code; // accepted code
  logic exc_rsv; // reserved code present
  logic exc_none; // no exception
  logic srst; // reset by exception code
  dcsc_exc_filter u_exc (
    .clk(clk),
    .rst_b(rst_b),
    .code_in({exception_code_line2, exception_code_line1, exception_code_line0}),
    .code_ok(exc_code),
    .code_rsv(exc_rsv)
  );
  assign exc_none = (exc_code == EXC_NONE);
  assign srst = (exc_code == EXC_RESET);
  assign exc_hold = (exc_code == EXC_HALT) || (exc_code == EXC_RETRY) || (exc_code == EXC_RR);
  assign cyc_end = data_transfer_acknowledge && !exc_rsv;

  // line detectors per channel
  logic [3:0] pcl_lvl; // line levels
  logic [3:0] pcl_fall; // qualified falls
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_pcl
      dcsc_pcl_edge u_pcl (
        .clk(clk),
        .rst_b(rst_b),
        .line_in(peripheral_control_line[gi]),
        .level(pcl_lvl[gi]),
        .fall_p(pcl_fall[gi])
      );
    end
  endgenerate

  // status and control state
  logic [3:0] coc_ff, blk_ff, ndt_ff, err_ff, act_ff, pct_ff;
  logic [3:0] start_ff, cont_ff, inten_ff, pclint_ff, fpend_ff, exh_ff;
  logic [3:0][1:0] chain_ff, prio_ff;
  logic [3:0][7:0] cer_ff, nvec_ff, evec_ff;
  logic [3:0] nxt_coc, nxt_blk, nxt_ndt, nxt_err, nxt_act, nxt_pct;
  logic [3:0] nxt_start, nxt_cont, nxt_inten, nxt_pclint, nxt_fpend, nxt_exh;
  logic [3:0][1:0] nxt_chain, nxt_prio;
  logic [3:0][7:0] nxt_cer, nxt_nvec, nxt_evec;
  // address and count state
  logic [3:0][31:0] mar_ff, bar_ff, nxt_mar, nxt_bar;
  logic [3:0][15:0] mtc_ff, btc_ff, nxt_mtc, nxt_btc;
  logic [3:0][2:0] bfc_ff, nxt_bfc;
  // sequencer state
  dcsc_sq_t sq_ff, nxt_sq;
  logic [1:0] sel_ff, nxt_sel; // channel being fetched
  logic [2:0] word_ff, nxt_word; // word index
  logic [4:0][15:0] buf_ff, nxt_buf; // entry words
  logic [31:0] faddr_ff, nxt_faddr;
  logic [2:0] ffc_ff, nxt_ffc;
  logic sq_take, sq_odd, sq_apply; // sequencer events
  logic [1:0] sq_ch; // channel picked when idle
  // interrupt and read path
  logic [3:0] chreq; // per-channel request
  logic [1:0] ack_ch; // channel presenting vector
  logic [7:0] vec_ff, nxt_vec;
  logic vack_ff, nxt_vack;
  logic [15:0] rd_ff, nxt_rd;
  logic [1:0] rch; // addressed channel
  logic [5:0] roff; // addressed offset
  assign rch = reg_addr[7:6];
  assign roff = reg_addr[5:0];

  // best priority in mask, low channel on tie
  function automatic logic [1:0] pick(input logic [3:0] m, input logic [3:0][1:0] p);
    logic [1:0] best;
    logic found;
    best = 2'h0;
    found = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (m[i] && (!found || p[i] < p[best])) begin
        best = 2'(i);
        found = 1'b1;
      end
    end
    return best;
  endfunction

  // descriptor fetch sequencer
  always_comb begin
    nxt_sq = sq_ff;
    nxt_sel = sel_ff;
    nxt_word = word_ff;
    nxt_buf = buf_ff;
    nxt_faddr = faddr_ff;
    nxt_ffc = ffc_ff;
    sq_take = 1'b0;
    sq_odd = 1'b0;
    sq_apply = 1'b0;
    sq_ch = pick(fpend_ff, prio_ff);
    case (sq_ff)
      SQ_IDLE: begin
        if ((|fpend_ff) && exc_none) begin
          sq_take = 1'b1;
          nxt_sel = sq_ch;
          if (bar_ff[sq_ch][0]) begin
            sq_odd = 1'b1;
          end else begin
            nxt_sq = SQ_FETCH;
            nxt_word = 3'h0;
            nxt_faddr = bar_ff[sq_ch];
            nxt_ffc = bfc_ff[sq_ch];
          end
        end
      end
      SQ_FETCH: begin
        if (fetch_ack) begin
          nxt_buf[word_ff] = fetch_data;
          nxt_word = word_ff + 3'h1;
          nxt_faddr = faddr_ff + 32'h0000_0002;
          if (nxt_word == ((chain_ff[sel_ff] == CHN_LINK) ? LNK_WORDS : ARR_WORDS)) begin
            nxt_sq = SQ_APPLY;
          end
        end
      end
      SQ_APPLY: begin
        sq_apply = 1'b1;
        nxt_sq = SQ_IDLE;
      end
      default: nxt_sq = SQ_IDLE;
    endcase
  end

  // register sequencer
  always_ff @(posedge clk) begin
    if (!rst_b || srst) begin
      sq_ff <= SQ_IDLE;
      sel_ff <= 2'h0;
      word_ff <= 3'h0;
      buf_ff <= '0;
      faddr_ff <= 32'h0000_0000;
      ffc_ff <= 3'h0;
    end else begin
      sq_ff <= nxt_sq;
      sel_ff <= nxt_sel;
      word_ff <= nxt_word;
      buf_ff <= nxt_buf;
      faddr_ff <= nxt_faddr;
      ffc_ff <= nxt_ffc;
    end
  end
  assign fetch_req = (sq_ff == SQ_FETCH);
  assign fetch_addr = faddr_ff;
  assign fetch_fc = ffc_ff;

  // per-channel status, control and chaining
  always_comb begin
    logic wr_sel, seterr;
    logic [7:0] ecode;
    logic [31:0] link;
    wr_sel = 1'b0;
    seterr = 1'b0;
    ecode = 8'h00;
    link = 32'h0000_0000;
    {nxt_coc, nxt_blk, nxt_ndt, nxt_err, nxt_act, nxt_pct} = {coc_ff, blk_ff, ndt_ff, err_ff, act_ff, pct_ff};
    {nxt_start, nxt_cont, nxt_inten, nxt_pclint} = {start_ff, cont_ff, inten_ff, pclint_ff};
    nxt_fpend = fpend_ff;
    nxt_exh = exh_ff;
    nxt_chain = chain_ff;
    nxt_prio = prio_ff;
    nxt_cer = cer_ff;
    nxt_nvec = nvec_ff;
    nxt_evec = evec_ff;
    nxt_mar = mar_ff;
    nxt_bar = bar_ff;
    nxt_mtc = mtc_ff;
    nxt_btc = btc_ff;
    nxt_bfc = bfc_ff;
    for (int c = 0; c < NCH; c++) begin
      wr_sel = reg_wr && (rch == 2'(c));
      seterr = 1'b0;
      ecode = 8'h00;
      // software writes first, so hardware sets below win
      if (wr_sel) begin
        case (roff)
          OFF_STAT: begin
            if (reg_wdata[ST_COC]) nxt_coc[c] = 1'b0;
            if (reg_wdata[ST_BLK]) nxt_blk[c] = 1'b0;
            if (reg_wdata[ST_NDT]) nxt_ndt[c] = 1'b0;
            if (reg_wdata[ST_ERR]) nxt_err[c] = 1'b0;
            if (reg_wdata[ST_PCT]) nxt_pct[c] = 1'b0;
          end
          OFF_MODE: begin
            nxt_chain[c] = reg_wdata[MD_CHAIN_LO+1:MD_CHAIN_LO];
            nxt_pclint[c] = reg_wdata[MD_PCLINT];
          end
          OFF_CTRL: begin
            nxt_inten[c] = reg_wdata[CT_INTEN];
            if (reg_wdata[CT_START]) begin
              if (act_ff[c] || coc_ff[c] || blk_ff[c] || ndt_ff[c] || err_ff[c]) begin
                seterr = 1'b1;
                ecode = ERC_TIMING;
              end else if (reg_wdata[CT_CONT] && chain_ff[c] != CHN_NONE) begin
                seterr = 1'b1;
                ecode = ERC_CONFIG;
              end else if ((chain_ff[c] == CHN_NONE && mtc_ff[c] == 16'h0000) ||
                           (chain_ff[c] == CHN_ARRAY && btc_ff[c] == 16'h0000)) begin
                seterr = 1'b1;
                ecode = ERC_COUNT;
              end else begin
                nxt_act[c] = 1'b1;
                nxt_start[c] = 1'b0;
                nxt_cont[c] = reg_wdata[CT_CONT];
                nxt_exh[c] = 1'b0;
                nxt_fpend[c] = (chain_ff[c] != CHN_NONE);
              end
            end else if (reg_wdata[CT_CONT]) begin
              if (chain_ff[c] != CHN_NONE || !act_ff[c] || blk_ff[c]) begin
                seterr = 1'b1;
                ecode = (chain_ff[c] != CHN_NONE) ? ERC_CONFIG : ERC_TIMING;
              end else begin
                nxt_cont[c] = 1'b1;
              end
            end
          end
          OFF_MTC: nxt_mtc[c] = reg_wdata;
          OFF_MARH: nxt_mar[c][31:16] = reg_wdata;
          OFF_MARL: nxt_mar[c][15:0] = reg_wdata;
          OFF_BTC: nxt_btc[c] = reg_wdata;
          OFF_BARH: nxt_bar[c][31:16] = reg_wdata;
          OFF_BARL: nxt_bar[c][15:0] = reg_wdata;
          OFF_NVEC: nxt_nvec[c] = reg_wdata[7:0];
          OFF_EVEC: nxt_evec[c] = reg_wdata[7:0];
          OFF_PRIO: nxt_prio[c] = reg_wdata[1:0];
          OFF_BFC: nxt_bfc[c] = reg_wdata[2:0];
          default: ;
        endcase
      end
      // peripheral line transition
      if (pcl_fall[c]) nxt_pct[c] = 1'b1;
      // peripheral terminates while acknowledged
      if (done_in[c] && periph_ack[c] && act_ff[c]) begin
        nxt_ndt[c] = 1'b1;
        nxt_coc[c] = 1'b1;
        nxt_act[c] = 1'b0;
        nxt_fpend[c] = 1'b0;
      end
      // memory counter exhausted
      if (blk_end[c] && act_ff[c]) begin
        if (cont_ff[c]) begin
          nxt_mar[c] = bar_ff[c];
          nxt_mtc[c] = btc_ff[c];
          nxt_blk[c] = 1'b1;
          nxt_cont[c] = 1'b0;
          if (btc_ff[c] == 16'h0000) begin
            seterr = 1'b1;
            ecode = ERC_COUNT;
          end
        end else if (chain_ff[c] != CHN_NONE && !exh_ff[c]) begin
          nxt_fpend[c] = 1'b1;
        end else begin
          nxt_act[c] = 1'b0;
          nxt_coc[c] = 1'b1;
        end
      end
      // sequencer took this channel
      if (sq_take && sq_ch == 2'(c)) begin
        nxt_fpend[c] = 1'b0;
        if (sq_odd) begin
          seterr = 1'b1;
          ecode = ERC_ADDR;
        end
      end
      // entry done: load, test end
      if (sq_apply && sel_ff == 2'(c)) begin
        nxt_mar[c] = {buf_ff[0], buf_ff[1]};
        nxt_mtc[c] = buf_ff[2];
        link = {buf_ff[3], buf_ff[4]};
        if (chain_ff[c] == CHN_LINK) begin
          nxt_bar[c] = link;
          nxt_exh[c] = (link == 32'h0000_0000);
        end else begin
          nxt_btc[c] = btc_ff[c] - 16'h0001;
          nxt_bar[c] = bar_ff[c] + ARR_STEP;
          nxt_exh[c] = (nxt_btc[c] == 16'h0000);
        end
        if (buf_ff[2] == 16'h0000) begin
          seterr = 1'b1;
          ecode = ERC_COUNT;
        end
      end
      // transfer and bus errors
      if (ext_err[c]) begin
        seterr = 1'b1;
        ecode = ext_err_code;
      end
      if (exc_code == EXC_BERR && cyc_busy && cyc_ch == 2'(c) && act_ff[c]) begin
        seterr = 1'b1;
        ecode = ERC_BUS;
      end
      // any error stops the channel
      if (seterr) begin
        nxt_err[c] = 1'b1;
        nxt_cer[c] = ecode;
        nxt_coc[c] = 1'b1;
        nxt_act[c] = 1'b0;
        nxt_start[c] = 1'b0;
        nxt_cont[c] = 1'b0;
        nxt_fpend[c] = 1'b0;
      end
    end
  end

  // status and control; exception reset too
  always_ff @(posedge clk) begin
    if (!rst_b || srst) begin
      {coc_ff, blk_ff, ndt_ff, err_ff, act_ff, pct_ff} <= '0;
      {start_ff, cont_ff, inten_ff, pclint_ff, fpend_ff, exh_ff} <= '0;
      chain_ff <= '0;
      prio_ff <= '0;
      cer_ff <= '0;
      nvec_ff <= {NCH{VEC_RST}};
      evec_ff <= {NCH{VEC_RST}};
    end else begin
      {coc_ff, blk_ff, ndt_ff, err_ff, act_ff, pct_ff} <= {nxt_coc, nxt_blk, nxt_ndt, nxt_err, nxt_act, nxt_pct};
      {start_ff, cont_ff, inten_ff, pclint_ff} <= {nxt_start, nxt_cont, nxt_inten, nxt_pclint};
      fpend_ff <= nxt_fpend;
      exh_ff <= nxt_exh;
      chain_ff <= nxt_chain;
      prio_ff <= nxt_prio;
      cer_ff <= nxt_cer;
      nvec_ff <= nxt_nvec;
      evec_ff <= nxt_evec;
    end
  end

  // addresses and counts; pin reset only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mar_ff <= '0;
      bar_ff <= '0;
      mtc_ff <= '0;
      btc_ff <= '0;
      bfc_ff <= '0;
    end else begin
      mar_ff <= nxt_mar;
      bar_ff <= nxt_bar;
      mtc_ff <= nxt_mtc;
      btc_ff <= nxt_btc;
      bfc_ff <= nxt_bfc;
    end
  end

  // request, vector, read data
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chreq[c] = inten_ff[c] && (coc_ff[c] || blk_ff[c] || err_ff[c] || ndt_ff[c] ||
                 (pct_ff[c] && pclint_ff[c]));
    end
    ack_ch = pick(chreq, prio_ff);
    nxt_vack = 1'b0;
    nxt_vec = vec_ff;
    if (interrupt_acknowledge_in && (|chreq)) begin
      nxt_vack = 1'b1;
      nxt_vec = err_ff[ack_ch] ? evec_ff[ack_ch] : nvec_ff[ack_ch];
    end
    nxt_rd = 16'h0000;
    if (reg_rd) begin
      case (roff)
        OFF_STAT: nxt_rd = {8'h00, coc_ff[rch], blk_ff[rch], ndt_ff[rch], err_ff[rch], act_ff[rch],
                            1'b0, pct_ff[rch], pcl_lvl[rch]};
        OFF_ERR: nxt_rd = {8'h00, cer_ff[rch]};
        OFF_MODE: nxt_rd = {12'h000, chain_ff[rch], 1'b0, pclint_ff[rch]};
        OFF_CTRL: nxt_rd = {8'h00, start_ff[rch], cont_ff[rch], 2'h0, inten_ff[rch], 3'h0};
        OFF_MTC: nxt_rd = mtc_ff[rch];
        OFF_MARH: nxt_rd = mar_ff[rch][31:16];
        OFF_MARL: nxt_rd = mar_ff[rch][15:0];
        OFF_BTC: nxt_rd = btc_ff[rch];
        OFF_BARH: nxt_rd = bar_ff[rch][31:16];
        OFF_BARL: nxt_rd = bar_ff[rch][15:0];
        OFF_NVEC: nxt_rd = {8'h00, nvec_ff[rch]};
        OFF_EVEC: nxt_rd = {8'h00, evec_ff[rch]};
        OFF_PRIO: nxt_rd = {14'h0000, prio_ff[rch]};
        OFF_BFC: nxt_rd = {13'h0000, bfc_ff[rch]};
        default: nxt_rd = 16'h0000;
      endcase
    end
  end

  // register vector and read data
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      vec_ff <= 8'h00;
      vack_ff <= 1'b0;
      rd_ff <= 16'h0000;
    end else begin
      vec_ff <= nxt_vec;
      vack_ff <= nxt_vack;
      rd_ff <= nxt_rd;
    end
  end

  assign int_req = |chreq;
  assign vec_data = vec_ff;
  assign vec_data_transfer_acknowledge = vack_ff;
  assign reg_rdata = rd_ff;
  assign chan_active = act_ff;
  assign bus_request_out = (|(xfer_req & act_ff)) && exc_none;
endmodule
`default_nettype wire

/* File: dcsc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dcsc_top_assertions (
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic interrupt_acknowledge_in, // ack
  input wire logic int_req, // irq
  input wire logic vec_data_transfer_acknowledge, // vector
  input wire logic [3:0] xfer_req, // reqs
  input wire logic [3:0] chan_active, // act
  input wire logic bus_request_out, // br
  input wire logic exc_hold, // hold
  input wire logic data_transfer_acknowledge, // data_transfer_acknowledge
  input wire logic cyc_end, // end
  input wire logic fetch_req, // fetch
  input wire logic fetch_ack, // word
  input wire logic [31:0] fetch_addr // addr
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // a table word handed over
  sequence s_word;
    fetch_req && fetch_ack;
  endsequence
  // acknowledge while requesting
  sequence s_ack;
    interrupt_acknowledge_in && int_req;
  endsequence
  a_vec_answer: assert property (s_ack |=> vec_data_transfer_acknowledge)
    else $error("vector missing");
  a_vec_quiet: assert property (!(interrupt_acknowledge_in && int_req) |=> !vec_data_transfer_acknowledge)
    else $error("stray vector");
  a_br_cause: assert property (bus_request_out |-> |(xfer_req & chan_active))
    else $error("bus request without cause");
  a_br_hold: assert property (exc_hold |-> !bus_request_out)
    else $error("bus request under exception");
  a_end_data_transfer_acknowledge: assert property (cyc_end |-> data_transfer_acknowledge)
    else $error("cycle end without acknowledge");
  a_fetch_stand: assert property (fetch_req && !fetch_ack |=> fetch_req)
    else $error("fetch dropped early");
  a_fetch_step: assert property (s_word |=> !fetch_req || fetch_addr == $past(fetch_addr) + 32'h2)
    else $error("fetch address step");
  a_fetch_clear: assert property ($rose(fetch_req) |-> !$past(exc_hold))
    else $error("fetch under exception");
endmodule
bind dcsc_top dcsc_top_assertions dcsc_top_assertions_i (.*);
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcsc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic interrupt_acknowledge_in = 1'b0, data_transfer_acknowledge = 1'b0;
  logic int_req, vec_data_transfer_acknowledge, bus_request_out, cyc_end, exc_hold, fetch_req, fetch_ack;
  logic [2:0] exc = 3'h7, fetch_fc;
  logic [3:0] periph_ack = 4'h0, done_in = 4'h0, peripheral_control_line = 4'hf;
  logic [3:0] xfer_req = 4'h0, blk_end = 4'h0, chan_active;
  logic [7:0] reg_addr = 8'h0, vec_data, ev;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, fetch_data, m, q[$];
  logic [31:0] fetch_addr;
  int err_count = 0, num_checks = 0, cyc = 0;
  dcsc_top dcsc_top_i (.*, .ext_err(4'h0), .ext_err_code(8'h0), .cyc_busy(1'b0), .cyc_ch(2'h0),
    .exception_code_line0(exc[0]), .exception_code_line1(exc[1]), .exception_code_line2(exc[2]));
  dcsc_mem_model dcsc_mem_model_i (.*);
  // clock
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] c, input logic [5:0] o, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= {c, o};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] c, input logic [5:0] o, input logic [15:0] e, input bit v = 1'b0);
    @(posedge clk);
    q.push_back(e);
    reg_addr <= {c, o};
    reg_rd <= !v;
    interrupt_acknowledge_in <= v;
    @(posedge clk);
    reg_rd <= 1'b0;
    interrupt_acknowledge_in <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] b);
    @(posedge clk);
    blk_end <= b;
    @(posedge clk);
    blk_end <= 4'h0;
  endtask
  // start a chain, wait out the fetch
  task automatic chain(input logic [1:0] c, input logic [15:0] b, input logic [15:0] md);
    wr(c, OFF_BARL, b);
    wr(c, OFF_BFC, 16'h5);
    wr(c, OFF_MODE, md);
    wr(c, OFF_CTRL, 16'h80);
    for (int i = 0; i < 9 && fetch_req !== 1'b1; i++) @(posedge clk) #1;
    chk("fc", fetch_fc, 3'h5);
    chk("fa", fetch_addr, {16'h0, b});
    for (int i = 0; i < 30 && fetch_req !== 1'b0; i++) @(posedge clk) #1;
    repeat (3) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // oldest note vs result, timeout
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("rdata", reg_rdata, q.pop_front());
    if (vec_data_transfer_acknowledge === 1'b1) chk("vec", vec_data, q.pop_front());
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h51e5));
    ev = 8'($urandom());
    m = 16'($urandom_range(999, 1));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(c[1:0], OFF_NVEC, 16'hf);
      rd(c[1:0], OFF_EVEC, 16'hf);
    end
    wr(2'h0, OFF_EVEC, {8'h0, ev});
    wr(2'h0, OFF_CTRL, 16'h88);
    rd(2'h0, OFF_ERR, {8'h0, ERC_COUNT});
    wr(2'h0, OFF_STAT, 16'h0);
    rd(2'h0, OFF_STAT, 16'h91);
    chk("irq", int_req, 1'b1);
    wr(2'h0, OFF_CTRL, 16'h0);
    chk("irq", int_req, 1'b0);
    wr(2'h0, OFF_CTRL, 16'h8);
    chk("irq", int_req, 1'b1);
    wr(2'h1, OFF_MTC, m);
    wr(2'h1, OFF_CTRL, 16'h88);
    chk("act", chan_active, 4'h2);
    wr(2'h1, OFF_STAT, 16'hffff);
    done_in <= 4'h2;
    rd(2'h1, OFF_STAT, 16'h9);
    periph_ack <= 4'h2;
    @(posedge clk);
    periph_ack <= 4'h0;
    done_in <= 4'h0;
    rd(2'h1, OFF_STAT, 16'ha1);
    rd(2'h0, 6'h0, {8'h0, ev}, 1'b1);
    wr(2'h0, OFF_PRIO, 16'h1);
    rd(2'h0, 6'h0, 16'hf, 1'b1);
    wr(2'h1, OFF_STAT, 16'hff);
    wr(2'h0, OFF_STAT, 16'h90);
    chk("irq", int_req, 1'b0);
    peripheral_control_line <= 4'he;
    repeat (4) @(posedge clk);
    peripheral_control_line <= 4'hf;
    rd(2'h0, OFF_STAT, 16'h3);
    wr(2'h0, OFF_MODE, 16'h1);
    chk("irq", int_req, 1'b1);
    dcsc_mem_model_i.mem[0] = 16'h1;
    dcsc_mem_model_i.mem[1] = 16'h2000;
    dcsc_mem_model_i.mem[2] = m;
    wr(2'h2, OFF_BTC, 16'h1);
    chain(2'h2, 16'h100, 16'h8);
    rd(2'h2, OFF_MARL, 16'h2000);
    rd(2'h2, OFF_MTC, m);
    rd(2'h2, OFF_BTC, 16'h0);
    rd(2'h2, OFF_BARL, 16'h106);
    xfer_req <= 4'h4;
    data_transfer_acknowledge <= 1'b1;
    for (int c = 1; c < 8; c++) begin
      @(posedge clk);
      exc <= c[2:0];
      repeat (3) @(posedge clk) #1;
      chk("hold", exc_hold, c == 6 || c == 4 || c == 3);
      chk("br", bus_request_out, c == 7);
      chk("end", cyc_end, c > 2);
    end
    xfer_req <= 4'h0;
    pulse(4'h4);
    rd(2'h2, OFF_STAT, 16'h81);
    dcsc_mem_model_i.mem[9] = 16'h4000;
    dcsc_mem_model_i.mem[10] = m;
    chain(2'h3, 16'h110, 16'hc);
    rd(2'h3, OFF_MTC, m);
    rd(2'h3, OFF_BARL, 16'h0);
    pulse(4'h8);
    rd(2'h3, OFF_STAT, 16'h81);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
